// ### include/cie_pkg.sv
// package of the card interface interrupt enable block
// assumes an apb slave with 32-bit data and byte addresses
package cie_pkg;

  localparam int CIE_ADDR_WIDTH = 8;
  localparam int CIE_DATA_WIDTH = 32;
  localparam int CIE_EVENT_COUNT = 11;
  localparam int CIE_GROUP_COUNT = 3;

  // register byte addresses
  localparam logic [7:0] CIE_OFS_EVENT_ENABLE_MASK = 8'h00;
  localparam logic [7:0] CIE_OFS_GROUP_AND_ERROR_ENABLE = 8'h04;
  localparam logic [7:0] CIE_OFS_REQUEST_STATUS = 8'h08;
  localparam logic [7:0] CIE_OFS_EVENT_FLAGS_FIRST = 8'h0C;
  localparam logic [7:0] CIE_OFS_EVENT_FLAGS_SECOND = 8'h10;
  localparam logic [7:0] CIE_OFS_CLEAR_FIRST = 8'h14;
  localparam logic [7:0] CIE_OFS_CLEAR_SECOND = 8'h18;

  // reset values
  localparam logic [7:0] CIE_RST_EVENT_ENABLE_MASK = 8'h00;
  localparam logic [7:0] CIE_RST_GROUP_AND_ERROR_ENABLE = 8'h00;
  localparam logic [31:0] CIE_RST_READ_DATA = 32'h0000_0000;

  // writable bits of the second enable register, bits 4 and 3 reserved
  localparam logic [7:0] CIE_GROUP_AND_ERROR_WRITABLE = 8'hE7;

  // bit positions in event_enable_mask and event_flags_first
  localparam int CIE_BIT_FIFO_EMPTY = 7;
  localparam int CIE_BIT_FIFO_FULL = 6;
  localparam int CIE_BIT_DATA_RESPONSE = 5;
  localparam int CIE_BIT_TRANSFER_END = 4;
  localparam int CIE_BIT_RESPONSE_END = 3;
  localparam int CIE_BIT_CMD_SENT = 2;
  localparam int CIE_BIT_BUSY_END = 1;
  localparam int CIE_BIT_MULTIBLOCK_END = 0;

  // bit positions in group_and_error_enable and event_flags_second
  localparam int CIE_BIT_GROUP2_SOURCE = 7;
  localparam int CIE_BIT_GROUP1_SOURCE = 6;
  localparam int CIE_BIT_GROUP0_SOURCE = 5;
  localparam int CIE_BIT_CRC_ERROR = 2;
  localparam int CIE_BIT_DATA_TIMEOUT = 1;
  localparam int CIE_BIT_CMD_TIMEOUT = 0;
  localparam int CIE_ERROR_WIDTH = 3;

  // bit 0 of the request status register
  localparam int CIE_BIT_REQUEST_SUMMARY = 0;

  // flag vector: bits 7..0 first flags, bits 10..8 error flags
  localparam int CIE_VEC_ERROR_BASE = 8;
  localparam logic [10:0] CIE_GROUP0_MEMBERS = 11'h0C0;
  localparam logic [10:0] CIE_GROUP1_MEMBERS = 11'h03F;
  localparam logic [10:0] CIE_GROUP2_MEMBERS = 11'h700;

  typedef struct packed {
    logic [7:0] event_enable_mask;
    logic [7:0] group_and_error_enable;
    logic [31:0] read_data;
    logic slave_error;
    logic [2:0] group_irq;
    logic request_summary;
  } cie_top_state_type;

  typedef struct packed {
    logic [10:0] flags;
  } cie_latch_state_type;

endpackage

// ### logic/cie_event_latch.sv
// sticky event flags, set by event inputs, cleared by write-one pulses
// assumes clear pulses last one cycle and come from the register bus
`timescale 1ns/1ns
module cie_event_latch
  import cie_pkg::*;
#(
  parameter int WIDTH = CIE_EVENT_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] set_event,
  input wire logic [WIDTH-1:0] clear_flag,
  output logic [WIDTH-1:0] flags
);

  cie_latch_state_type state;
  cie_latch_state_type next_state;

  always_comb begin
    next_state = state;
    // set beats clear in the same cycle
    next_state.flags = (state.flags & ~clear_flag[WIDTH-1:0]) | set_event[WIDTH-1:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;

endmodule

// ### logic/cie_top.sv
// apb register block for the card interface interrupt enables and flags
// assumes one clock, synchronous reset, event inputs synchronous to clk
//
// Summary of operation
// - fifo empty into group 0 when enabled
// - fifo full into group 0 when enabled
// - data response into group 1, spi only
// - transfer end into group 1 when enabled
// - response end into group 1 when enabled
// - command sent into group 1 when enabled
// - busy end into group 1 when enabled
// - multiblock end into group 1 when enabled
// - bit 7 gates the group 2 line
// - bit 6 gates the group 1 line
// - bit 5 gates the group 0 line
// - bits 4 and 3 read zero, ignore writes
// - crc error into group 2 when enabled
// - data timeout into group 2 when enabled
// - command timeout into group 2 when enabled
// - summary bit is or of enabled flags
`timescale 1ns/1ns
module cie_top
  import cie_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CIE_ADDR_WIDTH-1:0] paddr,
  input wire logic [CIE_DATA_WIDTH-1:0] pwdata,
  output logic [CIE_DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_mode,
  input wire logic fifo_empty_event,
  input wire logic fifo_full_event,
  input wire logic data_response_event,
  input wire logic transfer_end_event,
  input wire logic response_end_event,
  input wire logic cmd_sent_event,
  input wire logic busy_end_event,
  input wire logic multiblock_end_event,
  input wire logic crc_error_event,
  input wire logic data_timeout_event,
  input wire logic cmd_timeout_event,
  output logic group0_cpu_irq,
  output logic group1_cpu_irq,
  output logic group2_cpu_irq,
  output logic irq_request
);

  cie_top_state_type state;
  cie_top_state_type next_state;

  logic setup_phase;
  logic access_phase;
  logic write_access;
  logic addr_mapped;
  logic [CIE_EVENT_COUNT-1:0] raw_event;
  logic [CIE_EVENT_COUNT-1:0] clear_flag;
  logic [CIE_EVENT_COUNT-1:0] flags;
  logic [CIE_EVENT_COUNT-1:0] enable_vec;
  logic [CIE_EVENT_COUNT-1:0] mode_gate;
  logic [CIE_EVENT_COUNT-1:0] pending;
  logic [CIE_GROUP_COUNT-1:0] source_enable;
  logic [CIE_GROUP_COUNT-1:0] group_pending;
  logic [CIE_ERROR_WIDTH-1:0] error_flags;
  logic [7:0] second_enable_read;

  // apb phases, zero wait states
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign write_access = access_phase & pwrite & ~state.slave_error;

  always_comb begin
    case (paddr)
      CIE_OFS_EVENT_ENABLE_MASK: addr_mapped = 1'b1;
      CIE_OFS_GROUP_AND_ERROR_ENABLE: addr_mapped = 1'b1;
      CIE_OFS_REQUEST_STATUS: addr_mapped = 1'b1;
      CIE_OFS_EVENT_FLAGS_FIRST: addr_mapped = 1'b1;
      CIE_OFS_EVENT_FLAGS_SECOND: addr_mapped = 1'b1;
      CIE_OFS_CLEAR_FIRST: addr_mapped = 1'b1;
      CIE_OFS_CLEAR_SECOND: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  // event inputs in flag vector order
  always_comb begin
    raw_event = '0;
    raw_event[CIE_BIT_FIFO_EMPTY] = fifo_empty_event;
    raw_event[CIE_BIT_FIFO_FULL] = fifo_full_event;
    raw_event[CIE_BIT_DATA_RESPONSE] = data_response_event;
    raw_event[CIE_BIT_TRANSFER_END] = transfer_end_event;
    raw_event[CIE_BIT_RESPONSE_END] = response_end_event;
    raw_event[CIE_BIT_CMD_SENT] = cmd_sent_event;
    raw_event[CIE_BIT_BUSY_END] = busy_end_event;
    raw_event[CIE_BIT_MULTIBLOCK_END] = multiblock_end_event;
    raw_event[CIE_VEC_ERROR_BASE + CIE_BIT_CRC_ERROR] = crc_error_event;
    raw_event[CIE_VEC_ERROR_BASE + CIE_BIT_DATA_TIMEOUT] = data_timeout_event;
    raw_event[CIE_VEC_ERROR_BASE + CIE_BIT_CMD_TIMEOUT] = cmd_timeout_event;
  end

  // write-one-to-clear pulses
  always_comb begin
    clear_flag = '0;
    if (write_access && paddr == CIE_OFS_CLEAR_FIRST) begin
      clear_flag[CIE_VEC_ERROR_BASE-1:0] = pwdata[CIE_VEC_ERROR_BASE-1:0];
    end
    if (write_access && paddr == CIE_OFS_CLEAR_SECOND) begin
      clear_flag[CIE_EVENT_COUNT-1:CIE_VEC_ERROR_BASE] = pwdata[CIE_ERROR_WIDTH-1:0];
    end
  end

  cie_event_latch #(
    .WIDTH(CIE_EVENT_COUNT)
  ) u_event_latch (
    .clk(clk),
    .rst(rst),
    .set_event(raw_event),
    .clear_flag(clear_flag),
    .flags(flags)
  );

  assign error_flags = flags[CIE_EVENT_COUNT-1:CIE_VEC_ERROR_BASE];

  // per-event enable bits and mode gating
  assign enable_vec = {state.group_and_error_enable[CIE_ERROR_WIDTH-1:0], state.event_enable_mask};

  always_comb begin
    mode_gate = '1;
    mode_gate[CIE_BIT_DATA_RESPONSE] = spi_mode;
  end

  // each flag passes only with its own enable bit
  genvar gi;
  generate
    for (gi = 0; gi < CIE_EVENT_COUNT; gi = gi + 1) begin : g_pending
      assign pending[gi] = flags[gi] & enable_vec[gi] & mode_gate[gi];
    end
  endgenerate

  // group source enables
  assign source_enable[0] = state.group_and_error_enable[CIE_BIT_GROUP0_SOURCE];
  assign source_enable[1] = state.group_and_error_enable[CIE_BIT_GROUP1_SOURCE];
  assign source_enable[2] = state.group_and_error_enable[CIE_BIT_GROUP2_SOURCE];

  assign group_pending[0] = |(pending & CIE_GROUP0_MEMBERS);
  assign group_pending[1] = |(pending & CIE_GROUP1_MEMBERS);
  assign group_pending[2] = |(pending & CIE_GROUP2_MEMBERS);

  // reserved bits always read as zero
  assign second_enable_read = state.group_and_error_enable & CIE_GROUP_AND_ERROR_WRITABLE;

  always_comb begin
    next_state = state;
    // registered lines, two cycles after the event input or the enable write
    next_state.group_irq = group_pending & source_enable;
    next_state.request_summary = |pending;
    if (setup_phase) begin
      next_state.slave_error = ~addr_mapped;
      next_state.read_data = CIE_RST_READ_DATA;
      if (!pwrite) begin
        case (paddr)
          CIE_OFS_EVENT_ENABLE_MASK: begin
            next_state.read_data[7:0] = state.event_enable_mask;
          end
          CIE_OFS_GROUP_AND_ERROR_ENABLE: begin
            next_state.read_data[7:0] = second_enable_read;
          end
          CIE_OFS_REQUEST_STATUS: begin
            next_state.read_data[CIE_BIT_REQUEST_SUMMARY] = |pending;
          end
          CIE_OFS_EVENT_FLAGS_FIRST: begin
            next_state.read_data[CIE_VEC_ERROR_BASE-1:0] = flags[CIE_VEC_ERROR_BASE-1:0];
          end
          CIE_OFS_EVENT_FLAGS_SECOND: begin
            next_state.read_data[CIE_ERROR_WIDTH-1:0] = error_flags;
          end
          default: begin
            next_state.read_data = CIE_RST_READ_DATA;
          end
        endcase
      end
    end
    if (write_access) begin
      case (paddr)
        CIE_OFS_EVENT_ENABLE_MASK: begin
          next_state.event_enable_mask = pwdata[7:0];
        end
        CIE_OFS_GROUP_AND_ERROR_ENABLE: begin
          next_state.group_and_error_enable = pwdata[7:0] & CIE_GROUP_AND_ERROR_WRITABLE;
        end
        default: begin
          next_state.event_enable_mask = state.event_enable_mask;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state.event_enable_mask <= CIE_RST_EVENT_ENABLE_MASK;
      state.group_and_error_enable <= CIE_RST_GROUP_AND_ERROR_ENABLE;
      state.read_data <= CIE_RST_READ_DATA;
      state.slave_error <= 1'b0;
      state.group_irq <= '0;
      state.request_summary <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign pready = access_phase;
  assign pslverr = access_phase & state.slave_error;
  assign prdata = state.read_data;
  assign group0_cpu_irq = state.group_irq[0];
  assign group1_cpu_irq = state.group_irq[1];
  assign group2_cpu_irq = state.group_irq[2];
  assign irq_request = state.request_summary;

endmodule

// ### tb/cie_monitor.sv
// port checks of cie_top
// assumes one clock and synchronous active high reset
`timescale 1ns/1ns
module cie_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic spi_mode,
  input wire logic fifo_empty_event,
  input wire logic fifo_full_event,
  input wire logic data_response_event,
  input wire logic transfer_end_event,
  input wire logic response_end_event,
  input wire logic cmd_sent_event,
  input wire logic busy_end_event,
  input wire logic multiblock_end_event,
  input wire logic crc_error_event,
  input wire logic data_timeout_event,
  input wire logic cmd_timeout_event,
  input wire logic group0_cpu_irq,
  input wire logic group1_cpu_irq,
  input wire logic group2_cpu_irq,
  input wire logic irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_reset;
    $fell(rst) |-> {group0_cpu_irq, group1_cpu_irq, group2_cpu_irq, irq_request} == 4'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("irq not cleared by reset");
  property p_g0_sum;
    group0_cpu_irq |-> irq_request;
  endproperty
  a_g0_sum: assert property (p_g0_sum) else $error("group 0 without summary");
  property p_g1_sum;
    group1_cpu_irq |-> irq_request;
  endproperty
  a_g1_sum: assert property (p_g1_sum) else $error("group 1 without summary");
  property p_g2_sum;
    group2_cpu_irq |-> irq_request;
  endproperty
  a_g2_sum: assert property (p_g2_sum) else $error("group 2 without summary");
  property p_g0_rise;
    $rose(group0_cpu_irq) |-> $past(fifo_empty_event || fifo_full_event || (psel && penable && pwrite), 2);
  endproperty
  a_g0_rise: assert property (p_g0_rise) else $error("group 0 rose without cause");
  property p_g1_rise;
    $rose(group1_cpu_irq) |-> $past(spi_mode) != $past(spi_mode, 2) || $past(data_response_event
      || transfer_end_event || response_end_event || cmd_sent_event || busy_end_event
      || multiblock_end_event || (psel && penable && pwrite), 2);
  endproperty
  a_g1_rise: assert property (p_g1_rise) else $error("group 1 rose without cause");
  property p_g2_rise;
    $rose(group2_cpu_irq) |-> $past(crc_error_event || data_timeout_event || cmd_timeout_event
      || (psel && penable && pwrite), 2);
  endproperty
  a_g2_rise: assert property (p_g2_rise) else $error("group 2 rose without cause");
  property p_req_fall;
    $fell(irq_request) |-> $past(spi_mode) != $past(spi_mode, 2) || $past(psel && penable && pwrite, 2)
      || $past(rst);
  endproperty
  a_req_fall: assert property (p_req_fall) else $error("summary fell without write");
endmodule
bind cie_top cie_monitor mon (.clk, .rst, .psel, .penable, .pwrite, .spi_mode, .fifo_empty_event,
  .fifo_full_event, .data_response_event, .transfer_end_event, .response_end_event, .cmd_sent_event,
  .busy_end_event, .multiblock_end_event, .crc_error_event, .data_timeout_event, .cmd_timeout_event,
  .group0_cpu_irq, .group1_cpu_irq, .group2_cpu_irq, .irq_request);

// ### tb/cie_cpu_model.sv
// cpu interrupt controller model: latches every line raised
// assumes level lines synchronous to clk
`timescale 1ns/1ns
module cie_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] irq_line,
  output logic [2:0] seen
);
  always_ff @(posedge clk) begin
    if (rst) begin
      seen <= 3'h0;
    end else begin
      seen <= seen | irq_line;
    end
  end
endmodule

// ### tb/tb.sv
// self-checking bench of cie_top: registers over apb and event routing
// assumes cie_pkg constants and a 25 MHz clock
`timescale 1ns/1ns
module tb;
  import cie_pkg::*;
  typedef struct packed {logic [3:0] irq; logic [31:0] data;} cie_note_type;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, spi_mode = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rnd = 32'h0000_C3D5, prdata;
  logic [10:0] ev = 11'h000;
  logic pready, pslverr, g0, g1, g2, irq_request;
  logic [2:0] seen;
  int fail_count = 0, n_tests = 0;
  cie_note_type notes[$];
  cie_note_type got;
  always #20 clk = ~clk;
  cie_top dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .spi_mode,
    .fifo_empty_event(ev[7]), .fifo_full_event(ev[6]), .data_response_event(ev[5]),
    .transfer_end_event(ev[4]), .response_end_event(ev[3]), .cmd_sent_event(ev[2]), .busy_end_event(ev[1]),
    .multiblock_end_event(ev[0]), .crc_error_event(ev[10]), .data_timeout_event(ev[9]),
    .cmd_timeout_event(ev[8]), .group0_cpu_irq(g0), .group1_cpu_irq(g1), .group2_cpu_irq(g2), .irq_request);
  cie_cpu_model cpu (.clk, .rst, .irq_line({g2, g1, g0}), .seen);
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  task automatic chk(input string what, input logic [35:0] s, input logic [35:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [3:0] q);
    notes.push_back('{q, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pulse(input logic [10:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 11'h000;
    repeat (3) @(posedge clk);
  endtask
  task automatic set_spi(input logic v);
    @(posedge clk);
    spi_mode <= v;
    repeat (2) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("counts: %0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      chk("pslverr", {35'h0, pslverr}, {35'h0, (paddr > CIE_OFS_CLEAR_SECOND) || (paddr[1:0] != 2'h0)});
      if (!pwrite) begin
        got = notes.pop_front();
        chk("read", {g2, g1, g0, irq_request, prdata}, {got.irq, got.data});
      end
    end
  end
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(CIE_OFS_EVENT_ENABLE_MASK, 32'h0, 4'h0);
    rd(CIE_OFS_GROUP_AND_ERROR_ENABLE, 32'h0, 4'h0);
    r = xs();
    wr(CIE_OFS_EVENT_ENABLE_MASK, r);
    rd(CIE_OFS_EVENT_ENABLE_MASK, {24'h0, r[7:0]}, 4'h0);
    wr(CIE_OFS_GROUP_AND_ERROR_ENABLE, r | 32'h18);
    rd(CIE_OFS_GROUP_AND_ERROR_ENABLE, {24'h0, r[7:0] & CIE_GROUP_AND_ERROR_WRITABLE}, 4'h0);
    rd(8'h40, 32'h0, 4'h0);
    wr(8'h40, 32'hFF);
    rd(CIE_OFS_EVENT_ENABLE_MASK, {24'h0, r[7:0]}, 4'h0);
    rd(CIE_OFS_CLEAR_FIRST, 32'h0, 4'h0);
    $display("test registers done");
    wr(CIE_OFS_EVENT_ENABLE_MASK, 32'hFF);
    wr(CIE_OFS_GROUP_AND_ERROR_ENABLE, 32'hFF);
    for (int i = 0; i < 11; i++) begin
      pulse(11'h001 << i);
      rd(CIE_OFS_REQUEST_STATUS, 32'h1, {CIE_GROUP2_MEMBERS[i], CIE_GROUP1_MEMBERS[i],
        CIE_GROUP0_MEMBERS[i], 1'b1});
      rd((i < 8) ? CIE_OFS_EVENT_FLAGS_FIRST : CIE_OFS_EVENT_FLAGS_SECOND, 32'h1 << (i % 8),
        {CIE_GROUP2_MEMBERS[i], CIE_GROUP1_MEMBERS[i], CIE_GROUP0_MEMBERS[i], 1'b1});
      if (i < 8) wr(CIE_OFS_CLEAR_FIRST, 32'h1 << i);
      else wr(CIE_OFS_CLEAR_SECOND, 32'h1 << (i - 8));
      rd(CIE_OFS_REQUEST_STATUS, 32'h0, 4'h0);
    end
    chk("cpu lines", {33'h0, seen}, {33'h0, 3'b111});
    $display("test routing done");
    wr(CIE_OFS_EVENT_ENABLE_MASK, 32'h00);
    wr(CIE_OFS_GROUP_AND_ERROR_ENABLE, 32'hE0);
    pulse(11'h7FF);
    rd(CIE_OFS_REQUEST_STATUS, 32'h0, 4'h0);
    rd(CIE_OFS_EVENT_FLAGS_FIRST, 32'hFF, 4'h0);
    rd(CIE_OFS_EVENT_FLAGS_SECOND, 32'h7, 4'h0);
    wr(CIE_OFS_GROUP_AND_ERROR_ENABLE, 32'h07);
    rd(CIE_OFS_REQUEST_STATUS, 32'h1, 4'b0001);
    wr(CIE_OFS_GROUP_AND_ERROR_ENABLE, 32'hE7);
    rd(CIE_OFS_REQUEST_STATUS, 32'h1, 4'b1001);
    wr(CIE_OFS_EVENT_ENABLE_MASK, 32'hC0);
    wr(CIE_OFS_GROUP_AND_ERROR_ENABLE, 32'h40);
    rd(CIE_OFS_REQUEST_STATUS, 32'h1, 4'b0001);
    wr(CIE_OFS_GROUP_AND_ERROR_ENABLE, 32'h20);
    rd(CIE_OFS_REQUEST_STATUS, 32'h1, 4'b0011);
    wr(CIE_OFS_GROUP_AND_ERROR_ENABLE, 32'h40);
    wr(CIE_OFS_EVENT_ENABLE_MASK, 32'h20);
    set_spi(1'b0);
    rd(CIE_OFS_REQUEST_STATUS, 32'h0, 4'h0);
    set_spi(1'b1);
    rd(CIE_OFS_REQUEST_STATUS, 32'h1, 4'b0101);
    $display("test gating done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(CIE_OFS_REQUEST_STATUS, 32'h0, 4'h0);
    rd(CIE_OFS_EVENT_ENABLE_MASK, 32'h0, 4'h0);
    rd(CIE_OFS_GROUP_AND_ERROR_ENABLE, 32'h0, 4'h0);
    $display("test second reset done");
    finish_test();
  end
endmodule
